//--- logic/decode_pkg.sv
package decode_pkg;

  // ********************************************************
  // fetch word layout
  // ********************************************************
  localparam int WORD_W      = 16;
  localparam int CLASS_MSB   = 7;
  localparam int CLASS_LSB   = 2;
  localparam int ALT_BIT     = 1;
  localparam int LONG_BIT    = 0;
  localparam int OPERAND_MSB = 15;
  localparam int OPERAND_LSB = 8;
  localparam int EXT_CNT_MSB = 13;
  localparam int EXT_CNT_LSB = 12;
  localparam int EXT_CNT_W   = 3;

  // ********************************************************
  // step sizes and reset values
  // ********************************************************
  localparam logic [1:0]           STEP_NONE   = 2'h0;
  localparam logic [1:0]           STEP_ONE    = 2'h1;
  localparam logic [1:0]           STEP_TWO    = 2'h2;
  localparam logic [EXT_CNT_W-1:0] EXT_CNT_RST = 3'h0;
  localparam logic [7:0]           OPERAND_RST = 8'h00;

  // ********************************************************
  // operation classes, value = opcode[7:2]
  // ********************************************************
  typedef enum logic [5:0] {
    op_nop = 6'h00, op_add_word = 6'h01, op_add_byte = 6'h02, op_sub_word = 6'h03,
    op_sub_byte = 6'h04, product_op = 6'h05, quotient_op = 6'h06,
    long_quotient_op = 6'h07, ones_invert_op = 6'h08, twos_invert_op = 6'h09,
    op_and_word = 6'h0A, op_and_byte = 6'h0B, op_or_word = 6'h0C, op_or_byte = 6'h0D,
    op_xor_word = 6'h0E, op_xor_byte = 6'h0F, bit_clear_set_op = 6'h10,
    bit_copy_op = 6'h11, bit_logic_op = 6'h12, bit_compare_op = 6'h13,
    masked_byte_modify = 6'h14, op_cmp_word = 6'h15, op_cmp_byte = 6'h16,
    compare_decrement = 6'h17, compare_increment = 6'h18, normalize_count = 6'h19,
    logical_shift = 6'h1A, rotate_op = 6'h1B, signed_shift_right = 6'h1C,
    op_move_word = 6'h1D, op_move_byte = 6'h1E, byte_extend_move = 6'h1F,
    conditional_jump = 6'h20, segment_jump = 6'h21, jump_bit_set = 6'h22,
    jump_bit_clear = 6'h23, conditional_call = 6'h24, segment_call = 6'h25,
    push_and_call = 6'h26, op_trap = 6'h27, op_push_pop = 6'h28,
    context_switch_push = 6'h29, intra_return = 6'h2A, inter_segment_return = 6'h2B,
    interrupt_return = 6'h2C, op_sw_break = 6'h2D, op_sw_reset = 6'h2E,
    op_idle = 6'h2F, op_wdt_service = 6'h30, op_wdt_switch = 6'h31,
    op_init_end = 6'h32, op_atomic_seq = 6'h33, reg_bank_override_seq = 6'h34,
    page_override_seq = 6'h35, segment_override_seq = 6'h36,
    retired_powerdown_op = 6'h37, op_illegal = 6'h3F
  } op_t;

  typedef enum logic [3:0] {
    grp_none = 4'h0, grp_arith = 4'h1, grp_logic = 4'h2, grp_bit = 4'h3,
    grp_compare = 4'h4, grp_shift = 4'h5, grp_move = 4'h6, grp_jump = 4'h7,
    grp_call = 4'h8, grp_return = 4'h9, grp_system = 4'hA, grp_ext = 4'hB
  } group_t;

  typedef enum logic [1:0] {
    mdu_none = 2'h0, mdu_mul = 2'h1, mdu_div_short = 2'h2, mdu_div_long = 2'h3
  } mdu_t;

  typedef enum logic [1:0] {
    ext_kind_reg = 2'h0, ext_kind_page = 2'h1, ext_kind_seg = 2'h2
  } ext_kind_t;

  typedef enum logic {
    ext_idle = 1'b0, ext_active = 1'b1
  } ext_state_t;

endpackage

//--- logic/decode_if.sv
`timescale 1ns/1ps

// ********************************************************
// class table lookup
// ********************************************************
interface table_if;
  decode_pkg::op_t    op;
  logic               long_form;
  decode_pkg::group_t group;
  logic               len4;
  logic               legal;
  decode_pkg::mdu_t   mdu_sel;

  modport table_end (input op, long_form, output group, len4, legal, mdu_sel);
  modport user_end  (output op, long_form, input group, len4, legal, mdu_sel);
endinterface

// ********************************************************
// override sequence tracker
// ********************************************************
interface ext_if;
  logic                                start;
  decode_pkg::ext_kind_t               kind;
  logic                                with_reg;
  logic [decode_pkg::EXT_CNT_W-1:0]    count;
  logic                                step;
  logic                                ext_reg;
  logic                                ext_page;
  logic                                ext_seg;

  modport tracker_end (input start, kind, with_reg, count, step,
                       output ext_reg, ext_page, ext_seg);
  modport user_end    (output start, kind, with_reg, count, step,
                       input ext_reg, ext_page, ext_seg);
endinterface

//--- logic/op_table.sv
`timescale 1ns/1ps

module op_table (
  table_if.table_end tb  // class lookup
);

  always_comb begin
    tb.group   = decode_pkg::grp_none;
    tb.len4    = 1'b0;
    tb.legal   = 1'b1;
    tb.mdu_sel = decode_pkg::mdu_none;
    case (tb.op)
      decode_pkg::op_add_word, decode_pkg::op_add_byte,
      decode_pkg::op_sub_word, decode_pkg::op_sub_byte: begin
        tb.group = decode_pkg::grp_arith;
        tb.len4  = tb.long_form;
      end
      decode_pkg::product_op: begin
        tb.group   = decode_pkg::grp_arith;
        tb.mdu_sel = decode_pkg::mdu_mul;
      end
      decode_pkg::quotient_op: begin
        tb.group   = decode_pkg::grp_arith;
        tb.mdu_sel = decode_pkg::mdu_div_short;
      end
      decode_pkg::long_quotient_op: begin
        tb.group   = decode_pkg::grp_arith;
        tb.mdu_sel = decode_pkg::mdu_div_long;
      end
      decode_pkg::ones_invert_op, decode_pkg::twos_invert_op: begin
        tb.group = decode_pkg::grp_arith;
      end
      decode_pkg::op_and_word, decode_pkg::op_and_byte, decode_pkg::op_or_word,
      decode_pkg::op_or_byte, decode_pkg::op_xor_word, decode_pkg::op_xor_byte: begin
        tb.group = decode_pkg::grp_logic;
        tb.len4  = tb.long_form;
      end
      decode_pkg::bit_clear_set_op: begin
        tb.group = decode_pkg::grp_bit;
      end
      decode_pkg::bit_copy_op, decode_pkg::bit_logic_op, decode_pkg::bit_compare_op: begin
        tb.group = decode_pkg::grp_bit;
        tb.len4  = 1'b1;
      end
      decode_pkg::masked_byte_modify: begin
        tb.group = decode_pkg::grp_bit;
        tb.len4  = 1'b1;
      end
      decode_pkg::op_cmp_word, decode_pkg::op_cmp_byte,
      decode_pkg::compare_decrement, decode_pkg::compare_increment: begin
        tb.group = decode_pkg::grp_compare;
        tb.len4  = tb.long_form;
      end
      decode_pkg::normalize_count, decode_pkg::logical_shift,
      decode_pkg::rotate_op, decode_pkg::signed_shift_right: begin
        tb.group = decode_pkg::grp_shift;
      end
      decode_pkg::op_move_word, decode_pkg::op_move_byte,
      decode_pkg::byte_extend_move: begin
        tb.group = decode_pkg::grp_move;
        tb.len4  = tb.long_form;
      end
      decode_pkg::conditional_jump, decode_pkg::segment_jump,
      decode_pkg::jump_bit_set, decode_pkg::jump_bit_clear: begin
        tb.group = decode_pkg::grp_jump;
        tb.len4  = 1'b1;
      end
      decode_pkg::conditional_call, decode_pkg::segment_call,
      decode_pkg::push_and_call: begin
        tb.group = decode_pkg::grp_call;
        tb.len4  = 1'b1;
      end
      decode_pkg::op_trap: begin
        tb.group = decode_pkg::grp_call;
      end
      decode_pkg::op_push_pop: begin
        tb.group = decode_pkg::grp_move;
      end
      decode_pkg::context_switch_push: begin
        tb.group = decode_pkg::grp_move;
        tb.len4  = 1'b1;
      end
      decode_pkg::intra_return, decode_pkg::inter_segment_return,
      decode_pkg::interrupt_return: begin
        tb.group = decode_pkg::grp_return;
      end
      decode_pkg::op_nop, decode_pkg::op_sw_break, decode_pkg::op_atomic_seq: begin
        tb.group = decode_pkg::grp_system;
      end
      decode_pkg::op_sw_reset, decode_pkg::op_idle, decode_pkg::op_wdt_service,
      decode_pkg::op_wdt_switch, decode_pkg::op_init_end,
      decode_pkg::retired_powerdown_op: begin
        tb.group = decode_pkg::grp_system;
        tb.len4  = 1'b1;
      end
      decode_pkg::reg_bank_override_seq: begin
        tb.group = decode_pkg::grp_ext;
      end
      decode_pkg::page_override_seq, decode_pkg::segment_override_seq: begin
        tb.group = decode_pkg::grp_ext;
        tb.len4  = tb.long_form;
      end
      default: begin
        tb.legal = 1'b0;
      end
    endcase
  end

endmodule

//--- logic/ext_tracker.sv
`timescale 1ns/1ps

module ext_tracker (
  input wire logic mclk,   // system clock
  input wire logic rst_n,  // async reset, active low
  ext_if.tracker_end ex    // override sequence port
);

  typedef struct packed {
    decode_pkg::ext_state_t           state;
    decode_pkg::ext_kind_t            kind;
    logic                             with_reg;
    logic [decode_pkg::EXT_CNT_W-1:0] cnt;
  } trk_t;

  trk_t s_q;
  trk_t s_d;

  // flags describe the instruction being taken now
  assign ex.ext_reg  = (s_q.state == decode_pkg::ext_active) &&
                       ((s_q.kind == decode_pkg::ext_kind_reg) || s_q.with_reg);
  assign ex.ext_page = (s_q.state == decode_pkg::ext_active) &&
                       (s_q.kind == decode_pkg::ext_kind_page);
  assign ex.ext_seg  = (s_q.state == decode_pkg::ext_active) &&
                       (s_q.kind == decode_pkg::ext_kind_seg);

  always_comb begin
    s_d = s_q;
    case (s_q.state)
      decode_pkg::ext_idle: begin
        if (ex.start) begin
          s_d.state    = decode_pkg::ext_active;
          s_d.kind     = ex.kind;
          s_d.with_reg = ex.with_reg;
          s_d.cnt      = ex.count;
        end
      end
      decode_pkg::ext_active: begin
        if (ex.start) begin
          s_d.kind     = ex.kind;
          s_d.with_reg = ex.with_reg;
          s_d.cnt      = ex.count;
        end else if (ex.step) begin
          s_d.cnt = s_q.cnt - 3'h1;
          if (s_q.cnt == 3'h1) begin
            s_d.state = decode_pkg::ext_idle;
          end
        end
      end
      default: begin
        s_d.state = decode_pkg::ext_idle;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{state: decode_pkg::ext_idle, kind: decode_pkg::ext_kind_reg,
               with_reg: 1'b0, cnt: decode_pkg::EXT_CNT_RST};
    end else begin
      s_q <= s_d;
    end
  end

endmodule

//--- logic/cpu_instruction_decode.sv
`timescale 1ns/1ps

// What this block does
// - add and subtract, word or byte, with or without carry, 2 or 4 bytes
// - signed or unsigned product goes to the 16x16 multiplier, 2 bytes
// - short quotient divides low product half by a register, 2 bytes
// - long quotient divides the 32-bit product pair by a register, 2 bytes
// - ones and twos inversion in place on word or byte register, 2 bytes
// - and, or, xor in word and byte forms, 2 or 4 bytes
// - bit clear/set 2 bytes; bit copy, bit logic, bit compare 4 bytes
// - masked high or low byte modify with immediate, 4 bytes
// - compare then decrement or increment register by 1 or 2
// - normalisation count into destination register, 2 bytes
// - shifts and rotates on one word register, 2 bytes; arithmetic keeps sign
// - byte to word move with sign or zero extension, 2 or 4 bytes
// - jump group all 4 bytes: conditional, segment, bit-test jumps
// - call group 4 bytes except trap: conditional, segment, push-and-call
// - trap enters service routine by immediate number, 2 bytes
// - context switch pushes register then loads it, 4 bytes
// - three 2-byte returns: intra, inter-segment, interrupt
// - page or segment override sequence start, optional registers, 2 or 4 bytes
// - register override sequence start, 2 bytes, following use extended space
// - retired power-down decodes as valid and does nothing

module cpu_instruction_decode (
  input  wire logic                    mclk,          // system clock, 40 MHz
  input  wire logic                    rst_n,         // async reset, active low
  input  wire logic                    fetch_valid,   // fetch word offered
  input  wire logic [15:0]             fetch_word,    // opcode byte and first operand byte
  output logic                         fetch_ready,   // decoder can take a word
  input  wire logic                    exec_ready,    // datapath takes the decode
  output logic                         dec_valid,     // decode result held
  output decode_pkg::op_t              dec_op,        // operation class
  output decode_pkg::group_t           dec_group,     // instruction group
  output logic                         dec_len4,      // 1: 4 bytes, 0: 2 bytes
  output logic                         dec_legal,     // opcode recognised
  output logic                         dec_byte_form, // byte operand form
  output logic                         dec_carry,     // carry or borrow used
  output logic                         dec_unsigned,  // unsigned product or quotient
  output decode_pkg::mdu_t             dec_mdu_sel,   // multiply/divide unit select
  output logic                         dec_mdu_wide,  // dividend is full product pair
  output logic                         dec_sign_fill, // fill with sign bit
  output logic [1:0]                   dec_step_amt,  // register step size 0/1/2
  output logic                         dec_step_up,   // step is increment
  output logic                         dec_alt_sel,   // variant select bit
  output logic [1:0]                   dec_sub_sel,   // four-way variant select
  output logic                         dec_no_effect, // no operation, no mode change
  output logic                         dec_ext_reg,   // extended register space
  output logic                         dec_ext_page,  // page override applies
  output logic                         dec_ext_seg,   // segment override applies
  output logic [7:0]                   dec_operand    // immediate operand byte
);

  // ********************************************************
  // registered decode state
  // ********************************************************
  typedef struct packed {
    logic               valid;
    decode_pkg::op_t    op;
    decode_pkg::group_t group;
    logic               len4;
    logic               legal;
    logic               byte_form;
    logic               carry;
    logic               unsgn;
    decode_pkg::mdu_t   mdu_sel;
    logic               mdu_wide;
    logic               sign_fill;
    logic [1:0]         step_amt;
    logic               step_up;
    logic               alt_sel;
    logic [1:0]         sub_sel;
    logic               no_effect;
    logic               ext_reg;
    logic               ext_page;
    logic               ext_seg;
    logic [7:0]         operand;
  } dec_t;

  dec_t s_q;
  dec_t s_d;

  table_if tb ();
  ext_if   ex ();

  decode_pkg::op_t op_raw;
  logic            alt;
  logic            accept;

  assign op_raw       = decode_pkg::op_t'(fetch_word[decode_pkg::CLASS_MSB:decode_pkg::CLASS_LSB]);
  assign alt          = fetch_word[decode_pkg::ALT_BIT];
  assign fetch_ready  = !s_q.valid || exec_ready;
  assign accept       = fetch_valid && fetch_ready;
  assign tb.op        = op_raw;
  assign tb.long_form = fetch_word[decode_pkg::LONG_BIT];

  // ********************************************************
  // sub-blocks
  // ********************************************************
  op_table u_table (
    .tb (tb)
  );

  ext_tracker u_ext (
    .mclk  (mclk),
    .rst_n (rst_n),
    .ex    (ex)
  );

  // ********************************************************
  // override sequence start and step
  // ********************************************************
  always_comb begin
    ex.start    = 1'b0;
    ex.kind     = decode_pkg::ext_kind_reg;
    ex.with_reg = 1'b0;
    ex.count    = {1'b0, fetch_word[decode_pkg::EXT_CNT_MSB:decode_pkg::EXT_CNT_LSB]} + 3'h1;
    ex.step     = accept;
    case (op_raw)
      decode_pkg::reg_bank_override_seq: begin
        ex.start = accept;
        ex.kind  = decode_pkg::ext_kind_reg;
      end
      decode_pkg::page_override_seq: begin
        ex.start    = accept;
        ex.kind     = decode_pkg::ext_kind_page;
        ex.with_reg = alt;
      end
      decode_pkg::segment_override_seq: begin
        ex.start    = accept;
        ex.kind     = decode_pkg::ext_kind_seg;
        ex.with_reg = alt;
      end
      default: begin
        ex.start = 1'b0;
      end
    endcase
  end

  // ********************************************************
  // next decode
  // ********************************************************
  always_comb begin
    s_d = s_q;
    if (accept) begin
      s_d.valid     = 1'b1;
      s_d.legal     = tb.legal;
      s_d.op        = tb.legal ? op_raw : decode_pkg::op_illegal;
      s_d.group     = tb.group;
      s_d.len4      = tb.len4;
      s_d.mdu_sel   = tb.mdu_sel;
      s_d.mdu_wide  = (op_raw == decode_pkg::long_quotient_op);
      s_d.alt_sel   = alt;
      s_d.sub_sel   = fetch_word[decode_pkg::ALT_BIT:decode_pkg::LONG_BIT];
      s_d.operand   = fetch_word[decode_pkg::OPERAND_MSB:decode_pkg::OPERAND_LSB];
      s_d.ext_reg   = ex.ext_reg;
      s_d.ext_page  = ex.ext_page;
      s_d.ext_seg   = ex.ext_seg;
      s_d.byte_form = 1'b0;
      s_d.carry     = 1'b0;
      s_d.unsgn     = 1'b0;
      s_d.sign_fill = 1'b0;
      s_d.step_amt  = decode_pkg::STEP_NONE;
      s_d.step_up   = 1'b0;
      s_d.no_effect = 1'b0;
      case (op_raw)
        decode_pkg::op_add_word, decode_pkg::op_sub_word: begin
          s_d.carry = alt;
        end
        decode_pkg::op_add_byte, decode_pkg::op_sub_byte: begin
          s_d.carry     = alt;
          s_d.byte_form = 1'b1;
        end
        decode_pkg::product_op, decode_pkg::quotient_op,
        decode_pkg::long_quotient_op: begin
          s_d.unsgn = alt;
        end
        decode_pkg::ones_invert_op, decode_pkg::twos_invert_op: begin
          s_d.byte_form = alt;
        end
        decode_pkg::op_and_byte, decode_pkg::op_or_byte, decode_pkg::op_xor_byte,
        decode_pkg::op_cmp_byte, decode_pkg::op_move_byte: begin
          s_d.byte_form = 1'b1;
        end
        decode_pkg::compare_decrement: begin
          s_d.step_amt = alt ? decode_pkg::STEP_TWO : decode_pkg::STEP_ONE;
        end
        decode_pkg::compare_increment: begin
          s_d.step_amt = alt ? decode_pkg::STEP_TWO : decode_pkg::STEP_ONE;
          s_d.step_up  = 1'b1;
        end
        decode_pkg::signed_shift_right: begin
          s_d.sign_fill = 1'b1;
        end
        decode_pkg::byte_extend_move: begin
          s_d.byte_form = 1'b1;
          s_d.sign_fill = !alt;
        end
        decode_pkg::op_nop, decode_pkg::retired_powerdown_op: begin
          s_d.no_effect = 1'b1;
        end
        default: begin
          s_d.no_effect = !tb.legal;
        end
      endcase
    end else if (exec_ready) begin
      s_d.valid = 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{valid: 1'b0, op: decode_pkg::op_nop, group: decode_pkg::grp_none,
               len4: 1'b0, legal: 1'b0, byte_form: 1'b0, carry: 1'b0, unsgn: 1'b0,
               mdu_sel: decode_pkg::mdu_none, mdu_wide: 1'b0, sign_fill: 1'b0,
               step_amt: decode_pkg::STEP_NONE, step_up: 1'b0, alt_sel: 1'b0,
               sub_sel: 2'h0, no_effect: 1'b0, ext_reg: 1'b0, ext_page: 1'b0,
               ext_seg: 1'b0, operand: decode_pkg::OPERAND_RST};
    end else begin
      s_q <= s_d;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign dec_valid     = s_q.valid;
  assign dec_op        = s_q.op;
  assign dec_group     = s_q.group;
  assign dec_len4      = s_q.len4;
  assign dec_legal     = s_q.legal;
  assign dec_byte_form = s_q.byte_form;
  assign dec_carry     = s_q.carry;
  assign dec_unsigned  = s_q.unsgn;
  assign dec_mdu_sel   = s_q.mdu_sel;
  assign dec_mdu_wide  = s_q.mdu_wide;
  assign dec_sign_fill = s_q.sign_fill;
  assign dec_step_amt  = s_q.step_amt;
  assign dec_step_up   = s_q.step_up;
  assign dec_alt_sel   = s_q.alt_sel;
  assign dec_sub_sel   = s_q.sub_sel;
  assign dec_no_effect = s_q.no_effect;
  assign dec_ext_reg   = s_q.ext_reg;
  assign dec_ext_page  = s_q.ext_page;
  assign dec_ext_seg   = s_q.ext_seg;
  assign dec_operand   = s_q.operand;

endmodule

//--- test/exec_sink.sv
`timescale 1ns/1ps
// ****************
// datapath acceptance model
// ****************
module exec_sink (
  input  wire logic dec_valid,  // decode held
  input  wire logic stall,      // hold off acceptance
  output logic      exec_ready  // decode taken this edge
);
  assign exec_ready = dec_valid && !stall;
endmodule

//--- test/decode_props.sv
`timescale 1ns/1ps
// ****************
// decode checks
// ****************
module decode_props (
  input wire logic               mclk,          // clock
  input wire logic               rst_n,         // reset
  input wire logic               fetch_valid,   // word offered
  input wire logic [15:0]        fetch_word,    // word
  input wire logic               fetch_ready,   // can take
  input wire logic               exec_ready,    // decode taken
  input wire logic               dec_valid,     // decode held
  input wire decode_pkg::op_t    dec_op,        // class
  input wire logic               dec_len4,      // 4 bytes
  input wire logic               dec_legal,     // recognised
  input wire logic               dec_no_effect, // no effect
  input wire decode_pkg::mdu_t   dec_mdu_sel,   // unit select
  input wire logic [1:0]         dec_step_amt,  // step
  input wire logic               dec_sign_fill  // sign fill
);
  logic       tk;
  logic [5:0] cls;
  assign tk = fetch_valid && fetch_ready;
  assign cls = fetch_word[7:2];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_answer; tk |=> dec_valid; endproperty
  a_answer: assert property (p_answer) else $error("no decode");
  property p_hold; dec_valid && !exec_ready |=> dec_valid && $stable(dec_op); endproperty
  a_hold: assert property (p_hold) else $error("decode lost");
  property p_long; tk && cls inside {[6'h20:6'h26], 6'h29} |=> dec_len4; endproperty
  a_long: assert property (p_long) else $error("length not 4");
  property p_short;
    tk && cls inside {[6'h05:6'h09], [6'h19:6'h1C], 6'h27, [6'h2A:6'h2C], 6'h34} |=> !dec_len4;
  endproperty
  a_short: assert property (p_short) else $error("length not 2");
  property p_var;
    tk && cls inside {[6'h01:6'h04], [6'h0A:6'h0F], 6'h1F, 6'h35, 6'h36}
      |=> dec_len4 == $past(fetch_word[0]);
  endproperty
  a_var: assert property (p_var) else $error("length variant");
  property p_mdu; tk && cls inside {[6'h05:6'h07]} |=> dec_mdu_sel == $past(fetch_word[3:2]); endproperty
  a_mdu: assert property (p_mdu) else $error("unit select");
  property p_step;
    tk && cls inside {6'h17, 6'h18} |=> dec_step_amt == ($past(fetch_word[1]) ? 2'h2 : 2'h1);
  endproperty
  a_step: assert property (p_step) else $error("step size");
  property p_bits; tk && cls inside {[6'h10:6'h14]} |=> dec_len4 == ($past(cls) != 6'h10); endproperty
  a_bits: assert property (p_bits) else $error("bit length");
  property p_retired_powerdown_op; tk && cls == 6'h37 |=> dec_legal && dec_no_effect && dec_len4; endproperty
  a_retired_powerdown_op: assert property (p_retired_powerdown_op) else $error("retired op");
  property p_sign; tk && cls == 6'h1C |=> dec_sign_fill; endproperty
  a_sign: assert property (p_sign) else $error("sign fill");
endmodule
bind cpu_instruction_decode decode_props chk (.*);

//--- test/cpu_instruction_decode_tb.sv
`timescale 1ns/1ps
// ****************
// decoder bench
// ****************
module cpu_instruction_decode_tb;
  logic mclk, rst_n, fetch_valid, fetch_ready, exec_ready, stall, dec_valid, dec_len4;
  logic dec_legal, dec_byte_form, dec_carry, dec_unsigned, dec_mdu_wide, dec_sign_fill;
  logic dec_step_up, dec_alt_sel, dec_no_effect, dec_ext_reg, dec_ext_page, dec_ext_seg;
  logic [15:0]        fetch_word;
  logic [1:0]         dec_step_amt, dec_sub_sel;
  logic [7:0]         dec_operand;
  decode_pkg::op_t    dec_op;
  decode_pkg::group_t dec_group;
  decode_pkg::mdu_t   dec_mdu_sel;
  int                 n_mismatch, n_tests;

  cpu_instruction_decode uut (.*);
  exec_sink sink (.dec_valid, .stall, .exec_ready);

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task finish_test;
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_tests++;
    if (g !== e) begin
      $display("BAD %s exp %h got %h", n, e, g);
      n_mismatch++;
    end
  endtask

  task issue(input logic [15:0] w);
    int i;
    @(negedge mclk);
    fetch_valid = 1'b1;
    fetch_word = w;
    for (i = 0; i < 20 && fetch_ready !== 1'b1; i++) @(negedge mclk);
    if (i == 20) begin
      n_mismatch++;
      finish_test();
    end
    @(negedge mclk);
    fetch_valid = 1'b0;
  endtask

  function automatic logic exp_len(input logic [5:0] c, input logic l);
    if (c inside {[6'h11:6'h14], [6'h20:6'h26], 6'h29, [6'h2E:6'h32], 6'h37}) return 1'b1;
    if (c inside {[6'h01:6'h04], [6'h0A:6'h0F], [6'h15:6'h18], [6'h1D:6'h1F], 6'h35, 6'h36})
      return l;
    return 1'b0;
  endfunction

  task t_table;
    for (int c = 0; c < 64; c++) begin
      for (int l = 0; l < 2; l++) begin
        issue({8'hA5, 6'(c), 1'b0, 1'(l)});
        chk("op", (c < 56) ? 8'(c) : 8'h3F, 8'(dec_op));
        chk("len4", 8'(exp_len(6'(c), 1'(l))), 8'(dec_len4));
        chk("legal", 8'(c < 56), 8'(dec_legal));
        chk("no_effect", 8'(c == 0 || c >= 55), 8'(dec_no_effect));
      end
    end
  endtask

  task t_detail;
    issue(16'h0006);
    chk("carry", 8'h01, 8'(dec_carry));
    issue(16'h0016);
    chk("unsigned", 8'h01, 8'(dec_unsigned));
    issue(16'h001C);
    chk("wide", 8'h01, 8'(dec_mdu_wide));
    issue(16'h0026);
    chk("byte_form", 8'h01, 8'(dec_byte_form));
    chk("group", 8'(decode_pkg::grp_arith), 8'(dec_group));
    issue(16'h0062);
    chk("step_up", 8'h01, 8'(dec_step_up));
    chk("alt_sel", 8'h01, 8'(dec_alt_sel));
    issue(16'h5A9C);
    chk("operand", 8'h5A, 8'(dec_operand));
    chk("group", 8'(decode_pkg::grp_call), 8'(dec_group));
    issue(16'h007E);
    chk("sign_fill", 8'h00, 8'(dec_sign_fill));
    issue(16'h0082);
    chk("sub_sel", 8'h02, 8'(dec_sub_sel));
    chk("group", 8'(decode_pkg::grp_jump), 8'(dec_group));
    issue(16'h00DC);
    chk("no_effect", 8'h01, 8'(dec_no_effect));
  endtask

  task t_ext;
    issue(16'h10D4);
    chk("ext_page", 8'h00, 8'(dec_ext_page));
    for (int i = 0; i < 3; i++) begin
      issue(16'h0000);
      chk("ext_page", 8'(i < 2), 8'(dec_ext_page));
    end
    issue(16'h00D0);
    issue(16'h0000);
    chk("ext_reg", 8'h01, 8'(dec_ext_reg));
    issue(16'h0000);
    chk("ext_reg", 8'h00, 8'(dec_ext_reg));
    issue(16'h00DA);
    issue(16'h0000);
    chk("ext_seg", 8'h01, 8'(dec_ext_seg));
    chk("ext_reg", 8'h01, 8'(dec_ext_reg));
  endtask

  task t_stall;
    @(negedge mclk);
    stall = 1'b1;
    issue(16'h0050);
    @(negedge mclk);
    fetch_valid = 1'b1;
    fetch_word = 16'h0080;
    #1;
    chk("fetch_ready", 8'h00, 8'(fetch_ready));
    @(negedge mclk);
    chk("held_op", 8'h14, 8'(dec_op));
    stall = 1'b0;
    @(negedge mclk);
    fetch_valid = 1'b0;
    chk("next_op", 8'h20, 8'(dec_op));
  endtask

  initial begin
    rst_n = 1'b0;
    fetch_valid = 1'b0;
    fetch_word = 16'h0000;
    stall = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    repeat (16) @(negedge mclk);
    chk("reset_valid", 8'h00, 8'(dec_valid));
    rst_n = 1'b1;
    t_table();
    t_detail();
    t_ext();
    t_stall();
    finish_test();
  end
endmodule
